// *** mtd_control.sv ***
// Temperature scheduling, DAC code handling, shutdown and reference select.
`default_nettype none
`include "mtd_consts.svh"
// Operation
// - Flag trips when shunt exceeds fixed setpoint.
// - Flag also trips on low sense supply.
// - Flag latches until host clears it.
// - Temperatures refreshed in background every 5 ms.
// - Finished integration requests conversion autonomously.
// - Command mode: temperature runs after current conversion.
// - Autocycle: temperature inserted between sequence slots.
// - Idle ADC starts temperature conversion at once.
// - Latest result per temperature channel held.
// - Command mode may read out remote results.
// - Host signed offset added to remote results.
// - Each DAC takes a 12-bit code.
// - DAC codes are bit-inverted internally.
// - Die above 150 C tristates all DACs.
// - Shutdown sets the overtemperature alert bit.
// - Shutdown inactive while sensor powered down.
// - External references after reset; clear D4, D5.
module mtd_control #(
  parameter int unsigned TEMP_PERIOD_CYC = `MTD_TEMP_PERIOD_CYC,
  parameter int unsigned CONV_CYC        = `MTD_CONV_CYC_DEF
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_reset_n,
  input  wire logic [1:0]             i_shunt_above_setpoint,
  input  wire logic [1:0]             i_shunt_below_supply,
  input  wire logic [1:0]             i_shunt_clear,
  input  wire logic [1:0]             i_adc_mode,
  input  wire logic                   i_user_conv_start,
  input  wire logic                   i_slot_boundary,
  input  wire logic [11:0]            i_temp_raw,
  input  wire logic [11:0]            i_offset_r1,
  input  wire logic [11:0]            i_offset_r2,
  input  wire logic [1:0]             i_cmd_read_remote,
  input  wire logic                   i_cmd_read_strobe,
  input  wire mtd_pkg::mtd_dac_codes_t i_dac_codes,
  input  wire logic                   i_dac_load,
  input  wire logic [7:0]             i_pd_wdata,
  input  wire logic                   i_pd_write,
  input  wire logic                   i_overtemp_clear,
  output var  logic [1:0]             o_shunt_overload_flag,
  output var  logic                   o_temp_conv_active,
  output var  logic [1:0]             o_temp_conv_chan,
  output var  logic                   o_user_conv_active,
  output var  logic [11:0]            o_temp_r1,
  output var  logic [11:0]            o_temp_r2,
  output var  logic [11:0]            o_temp_int,
  output var  logic [11:0]            o_cmd_readout,
  output var  logic                   o_cmd_readout_valid,
  output var  mtd_pkg::mtd_dac_codes_t o_dac_tap,
  output var  logic                   o_dac_hiz,
  output var  logic                   o_overtemp_alert,
  output var  logic                   o_int_ref_adc_en,
  output var  logic                   o_int_ref_dac_en,
  output var  logic                   o_tsense_powered
);
  localparam int unsigned PW = $clog2(TEMP_PERIOD_CYC + 1);
  localparam int unsigned CW = $clog2(CONV_CYC + 1);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_shunt
      mtd_overrange u_or (
        .i_clock          (i_clock),
        .i_reset_n        (i_reset_n),
        .i_above_setpoint (i_shunt_above_setpoint[gi]),
        .i_below_supply   (i_shunt_below_supply[gi]),
        .i_clear          (i_shunt_clear[gi]),
        .o_flag           (o_shunt_overload_flag[gi])
      );
    end
  endgenerate

  // Integration timing: one channel finishes each third of the period.
  logic [PW-1:0]   integ_cnt_q, integ_cnt_d;
  logic [1:0]      integ_ch_q,  integ_ch_d;
  logic [2:0]      pend_q,      pend_d;
  logic            integ_done;
  localparam int unsigned SLICE = TEMP_PERIOD_CYC / `MTD_NUM_TEMP;

  assign integ_done = (integ_cnt_q == PW'(SLICE - 1));

  // ADC arbitration state.
  mtd_pkg::mtd_adc_state_t st_q, st_d;
  logic [CW-1:0]   conv_cnt_q, conv_cnt_d;
  logic [1:0]      cur_ch_q,   cur_ch_d;
  logic [1:0]      pick;
  logic            have_pend;
  logic            user_busy;
  logic            grant;

  always_comb begin
    pick = `MTD_CH_R1;
    if (!pend_q[0] && pend_q[1]) begin
      pick = `MTD_CH_R2;
    end else if (!pend_q[0] && !pend_q[1]) begin
      pick = `MTD_CH_INT;
    end
  end
  assign have_pend = |pend_q;
  assign user_busy = (st_q == mtd_pkg::MTD_ADC_USER);

  always_comb begin
    integ_cnt_d = integ_cnt_q + PW'(1);
    integ_ch_d  = integ_ch_q;
    pend_d      = pend_q;
    st_d        = st_q;
    conv_cnt_d  = conv_cnt_q;
    cur_ch_d    = cur_ch_q;
    grant       = 1'b0;
    if (integ_done) begin
      integ_cnt_d = '0;
      integ_ch_d  = (integ_ch_q == `MTD_CH_INT) ? `MTD_CH_R1 : integ_ch_q + 2'd1;
    end
    case (st_q)
      mtd_pkg::MTD_ADC_IDLE: begin
        if (have_pend) begin
          grant = 1'b1;
        end else if (i_user_conv_start) begin
          st_d       = mtd_pkg::MTD_ADC_USER;
          conv_cnt_d = CW'(CONV_CYC - 1);
        end
      end
      mtd_pkg::MTD_ADC_USER: begin
        if (conv_cnt_q != '0) begin
          conv_cnt_d = conv_cnt_q - CW'(1);
        end else if (have_pend && i_adc_mode == `MTD_MODE_CMD) begin
          grant = 1'b1;
        end else if (have_pend && i_adc_mode == `MTD_MODE_AUTO && i_slot_boundary) begin
          grant = 1'b1;
        end else begin
          st_d = mtd_pkg::MTD_ADC_IDLE;
        end
      end
      mtd_pkg::MTD_ADC_TEMP: begin
        if (conv_cnt_q != '0) begin
          conv_cnt_d = conv_cnt_q - CW'(1);
        end else begin
          st_d = mtd_pkg::MTD_ADC_IDLE;
        end
      end
      default: begin
        st_d = mtd_pkg::MTD_ADC_IDLE;
      end
    endcase
    if (grant) begin
      st_d         = mtd_pkg::MTD_ADC_TEMP;
      conv_cnt_d   = CW'(CONV_CYC - 1);
      cur_ch_d     = pick;
      pend_d[pick] = 1'b0;
    end
    if (integ_done) begin
      pend_d[integ_ch_q] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      integ_cnt_q <= '0;
      integ_ch_q  <= `MTD_CH_R1;
      pend_q      <= 3'b000;
      st_q        <= mtd_pkg::MTD_ADC_IDLE;
      conv_cnt_q  <= '0;
      cur_ch_q    <= `MTD_CH_R1;
    end else begin
      integ_cnt_q <= integ_cnt_d;
      integ_ch_q  <= integ_ch_d;
      pend_q      <= pend_d;
      st_q        <= st_d;
      conv_cnt_q  <= conv_cnt_d;
      cur_ch_q    <= cur_ch_d;
    end
  end

  // Result storage with offset correction on remote channels.
  logic [11:0] r1_q, r1_d, r2_q, r2_d, ti_q, ti_d;
  logic [11:0] rd_q, rd_d;
  logic        rdv_q, rdv_d;
  logic        temp_done;

  assign temp_done = (st_q == mtd_pkg::MTD_ADC_TEMP) && (conv_cnt_q == '0);

  always_comb begin
    r1_d  = r1_q;
    r2_d  = r2_q;
    ti_d  = ti_q;
    rd_d  = rd_q;
    rdv_d = 1'b0;
    if (temp_done) begin
      case (cur_ch_q)
        `MTD_CH_R1:  r1_d = i_temp_raw + i_offset_r1;
        `MTD_CH_R2:  r2_d = i_temp_raw + i_offset_r2;
        default:     ti_d = i_temp_raw;
      endcase
    end
    if (i_cmd_read_strobe && i_adc_mode == `MTD_MODE_CMD && |i_cmd_read_remote) begin
      rdv_d = 1'b1;
      rd_d  = i_cmd_read_remote[0] ? r1_q : r2_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r1_q  <= '0;
      r2_q  <= '0;
      ti_q  <= '0;
      rd_q  <= '0;
      rdv_q <= 1'b0;
    end else begin
      r1_q  <= r1_d;
      r2_q  <= r2_d;
      ti_q  <= ti_d;
      rd_q  <= rd_d;
      rdv_q <= rdv_d;
    end
  end

  // Power-down register, DAC taps and thermal shutdown.
  logic [7:0]              pd_q,   pd_d;
  mtd_pkg::mtd_dac_codes_t tap_q,  tap_d;
  logic                    hiz_q,  hiz_d;
  logic                    ota_q,  ota_d;
  logic                    hot;
  logic [4:0]              stat_q, stat_d;

  assign hot = !pd_q[`MTD_TSENSE_PD_BIT] && ($signed({4'h0, ti_q}) > $signed(`MTD_SHDN_LIMIT));

  always_comb begin
    pd_d  = pd_q;
    tap_d = tap_q;
    ota_d = ota_q;
    if (i_pd_write) begin
      pd_d = i_pd_wdata;
    end
    if (i_dac_load) begin
      tap_d = ~i_dac_codes;
    end
    hiz_d = hot;
    stat_d = {st_d == mtd_pkg::MTD_ADC_TEMP, st_d == mtd_pkg::MTD_ADC_USER,
              ~pd_d[`MTD_REF_ADC_BIT], ~pd_d[`MTD_REF_DAC_BIT], ~pd_d[`MTD_TSENSE_PD_BIT]};
    if (i_overtemp_clear) begin
      ota_d = 1'b0;
    end
    if (hot) begin
      ota_d = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pd_q  <= `MTD_PD_RESET;
      tap_q <= '1;
      hiz_q <= 1'b0;
      ota_q <= 1'b0;
      stat_q <= {2'b00, ~3'(`MTD_PD_RESET >> `MTD_TSENSE_PD_BIT)};
    end else begin
      pd_q  <= pd_d;
      tap_q <= tap_d;
      hiz_q <= hiz_d;
      ota_q <= ota_d;
      stat_q <= stat_d;
    end
  end

  assign o_temp_conv_active  = stat_q[4];
  assign o_temp_conv_chan    = cur_ch_q;
  assign o_user_conv_active  = stat_q[3];
  assign o_temp_r1           = r1_q;
  assign o_temp_r2           = r2_q;
  assign o_temp_int          = ti_q;
  assign o_cmd_readout       = rd_q;
  assign o_cmd_readout_valid = rdv_q;
  assign o_dac_tap           = tap_q;
  assign o_dac_hiz           = hiz_q;
  assign o_overtemp_alert    = ota_q;
  // The internal reference runs while its bit is zero.
  assign o_int_ref_adc_en    = stat_q[2];
  assign o_int_ref_dac_en    = stat_q[1];
  assign o_tsense_powered    = stat_q[0];

  property p_idle_starts;
    @(posedge i_clock) disable iff (!i_reset_n)
      (st_q == mtd_pkg::MTD_ADC_IDLE && have_pend) |=> (st_q == mtd_pkg::MTD_ADC_TEMP);
  endproperty
  a_idle_starts: assert property (p_idle_starts)
    else $error("Idle ADC did not start pending temperature conversion.");

  property p_cmd_follows;
    @(posedge i_clock) disable iff (!i_reset_n)
      (user_busy && conv_cnt_q == '0 && have_pend && i_adc_mode == `MTD_MODE_CMD)
      |=> (st_q == mtd_pkg::MTD_ADC_TEMP);
  endproperty
  a_cmd_follows: assert property (p_cmd_follows)
    else $error("Temperature conversion did not follow command conversion.");
  property p_integ_pends;
    @(posedge i_clock) disable iff (!i_reset_n)
      integ_done |=> pend_q[$past(integ_ch_q)];
  endproperty
  a_integ_pends: assert property (p_integ_pends)
    else $error("Finished integration raised no request.");
  property p_order;
    @(posedge i_clock) disable iff (!i_reset_n)
      (grant && pend_q[0]) |=> (cur_ch_q == `MTD_CH_R1);
  endproperty
  a_order: assert property (p_order)
    else $error("Requests not served in channel order.");
  property p_offset;
    @(posedge i_clock) disable iff (!i_reset_n)
      (temp_done && cur_ch_q == `MTD_CH_R1) |=> (r1_q == $past(i_temp_raw) + $past(i_offset_r1));
  endproperty
  a_offset: assert property (p_offset)
    else $error("Remote result lacks offset correction.");
  property p_invert;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_dac_load |=> (tap_q == ~$past(i_dac_codes));
  endproperty
  a_invert: assert property (p_invert)
    else $error("DAC code not inverted.");

  property p_shutdown;
    @(posedge i_clock) disable iff (!i_reset_n)
      hot |=> (hiz_q && ota_q);
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("Overtemperature did not tristate DACs and raise alert.");

  property p_pd_blocks;
    @(posedge i_clock) disable iff (!i_reset_n)
      pd_q[`MTD_TSENSE_PD_BIT] |=> !hiz_q;
  endproperty
  a_pd_blocks: assert property (p_pd_blocks)
    else $error("Shutdown active with sensor powered down.");
endmodule : mtd_control
`default_nettype wire

// *** mtd_consts.svh ***
// Constants for the monitor, temperature and DAC control block.
`ifndef MTD_CONSTS_SVH
`define MTD_CONSTS_SVH
`define MTD_CLK_MHZ         50
`define MTD_TEMP_PERIOD_US  5000
`define MTD_TEMP_PERIOD_CYC (`MTD_TEMP_PERIOD_US * `MTD_CLK_MHZ)
`define MTD_CONV_CYC_DEF    150
`define MTD_SHDN_LIMIT      16'h0258
`define MTD_REF_ADC_BIT     5
`define MTD_REF_DAC_BIT     4
`define MTD_TSENSE_PD_BIT   3
`define MTD_PD_RESET        8'h30
`define MTD_NUM_TEMP        3
`define MTD_NUM_DAC         4
`define MTD_DAC_W           12
`define MTD_TEMP_W          12
`define MTD_CH_R1           2'h0
`define MTD_CH_R2           2'h1
`define MTD_CH_INT          2'h2
`define MTD_MODE_IDLE       2'h0
`define MTD_MODE_CMD        2'h1
`define MTD_MODE_AUTO       2'h2
`endif

// *** mtd_pkg.sv ***
// Types shared by the monitor, temperature and DAC control block.
`default_nettype none
`include "mtd_consts.svh"
package mtd_pkg;
  typedef enum logic [1:0] {
    MTD_ADC_IDLE = 2'b00,
    MTD_ADC_USER = 2'b01,
    MTD_ADC_TEMP = 2'b10
  } mtd_adc_state_t;

  typedef struct packed {
    logic [1:0]  chan;
    logic [11:0] code;
  } mtd_temp_result_t;

  typedef struct packed {
    logic [11:0] code_a;
    logic [11:0] code_b;
    logic [11:0] code_c;
    logic [11:0] code_d;
  } mtd_dac_codes_t;
endpackage : mtd_pkg
`default_nettype wire

// *** mtd_overrange.sv ***
// Latching over-range flag for one shunt channel.
`default_nettype none
module mtd_overrange (
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  input  wire logic i_above_setpoint,
  input  wire logic i_below_supply,
  input  wire logic i_clear,
  output var  logic o_flag
);
  logic [1:0] sync_a_q, sync_a_d;
  logic [1:0] sync_b_q, sync_b_d;
  logic       flag_q,   flag_d;

  always_comb begin
    sync_a_d = {sync_a_q[0], i_above_setpoint};
    sync_b_d = {sync_b_q[0], i_below_supply};
    flag_d   = flag_q;
    if (i_clear) begin
      flag_d = 1'b0;
    end
    // A new trip in the clearing cycle wins over the clear.
    if (sync_a_q[1] || sync_b_q[1]) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_a_q <= 2'b00;
      sync_b_q <= 2'b00;
      flag_q   <= 1'b0;
    end else begin
      sync_a_q <= sync_a_d;
      sync_b_q <= sync_b_d;
      flag_q   <= flag_d;
    end
  end

  assign o_flag = flag_q;

  property p_trip_latches;
    @(posedge i_clock) disable iff (!i_reset_n)
      (sync_a_q[1] || sync_b_q[1]) |=> flag_q;
  endproperty
  a_trip_latches: assert property (p_trip_latches)
    else $error("Over-range trip did not set the flag.");

  property p_hold_until_clear;
    @(posedge i_clock) disable iff (!i_reset_n)
      (flag_q && !i_clear) |=> flag_q;
  endproperty
  a_hold_until_clear: assert property (p_hold_until_clear)
    else $error("Over-range flag dropped without a clear.");
endmodule : mtd_overrange
`default_nettype wire

// *** mtd_host_model.sv ***
// Host model that writes the power-down register and keeps the reference settling wait.
`default_nettype none
module mtd_host_model #(
  parameter int unsigned SETTLE_CYC = 3000
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic       i_req,
  input  wire logic [7:0] i_value,
  output var  logic [7:0] o_pd_wdata,
  output var  logic       o_pd_write,
  output var  logic       o_refs_settled
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_q;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pd_wdata     <= 8'h30;
      o_pd_write     <= 1'b0;
      o_refs_settled <= 1'b0;
      wait_q         <= 0;
    end else begin
      o_pd_write <= i_req;
      if (i_req) begin
        o_pd_wdata     <= i_value;
        o_refs_settled <= 1'b0;
        wait_q         <= (i_value[5:4] == 2'b00) ? SETTLE_CYC : 0;
      end else if (wait_q != 0) begin
        wait_q         <= wait_q - 1;
        o_refs_settled <= (wait_q == 1);
      end
    end
  end
endmodule : mtd_host_model
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the monitor, temperature and DAC control block.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned LIMIT = 12000;
  logic                    clk, rst_n;
  logic [1:0]              above, below, sclr, mode, rdsel, flag, tchan;
  logic                    ustart, slot, rdstb, load, pd_wr, otclr, mreq, tact, uact;
  logic                    rdval, hiz, alert, refa, refd, tpow, settled;
  logic [11:0]             raw, off1, off2, r1, r2, ti, rdout;
  logic [7:0]              pd_wdata, mval;
  mtd_pkg::mtd_dac_codes_t codes, taps;
  int                      errors = 0;
  int                      checks_done = 0;
  int                      cyc = 0;

  mtd_control #(.TEMP_PERIOD_CYC(300), .CONV_CYC(8)) i_dut (
    .i_clock                (clk),
    .i_reset_n              (rst_n),
    .i_shunt_above_setpoint (above),
    .i_shunt_below_supply   (below),
    .i_shunt_clear          (sclr),
    .i_adc_mode             (mode),
    .i_user_conv_start      (ustart),
    .i_slot_boundary        (slot),
    .i_temp_raw             (raw),
    .i_offset_r1            (off1),
    .i_offset_r2            (off2),
    .i_cmd_read_remote      (rdsel),
    .i_cmd_read_strobe      (rdstb),
    .i_dac_codes            (codes),
    .i_dac_load             (load),
    .i_pd_wdata             (pd_wdata),
    .i_pd_write             (pd_wr),
    .i_overtemp_clear       (otclr),
    .o_shunt_overload_flag  (flag),
    .o_temp_conv_active     (tact),
    .o_temp_conv_chan       (tchan),
    .o_user_conv_active     (uact),
    .o_temp_r1              (r1),
    .o_temp_r2              (r2),
    .o_temp_int             (ti),
    .o_cmd_readout          (rdout),
    .o_cmd_readout_valid    (rdval),
    .o_dac_tap              (taps),
    .o_dac_hiz              (hiz),
    .o_overtemp_alert       (alert),
    .o_int_ref_adc_en       (refa),
    .o_int_ref_dac_en       (refd),
    .o_tsense_powered       (tpow)
  );

  mtd_host_model i_host (
    .i_clock        (clk),
    .i_reset_n      (rst_n),
    .i_req          (mreq),
    .i_value        (mval),
    .o_pd_wdata     (pd_wdata),
    .o_pd_write     (pd_wr),
    .o_refs_settled (settled)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wait_n

  // Waits for the next conversion, which must be the given channel, then checks its result.
  task automatic conv(input logic [1:0] ch, input logic [11:0] exp);
    int n;
    n = 0;
    while (tact !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(tchan, ch);
    while (tact === 1'b1 && n < 420) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk((ch == 2'h0) ? r1 : (ch == 2'h1) ? r2 : ti, exp);
  endtask : conv

  task automatic seek_int();
    while (!(tact === 1'b1 && tchan === 2'h2)) @(negedge clk);
    while (tact === 1'b1) @(negedge clk);
  endtask : seek_int

  // Starts a user conversion that overlaps the next integration end, then checks the hand-over.
  task automatic overlap(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
    slot <= (m == 2'h2);
    while (tact === 1'b1) @(negedge clk);
    while (tact !== 1'b1) @(negedge clk);
    repeat (94) @(posedge clk);
    ustart <= 1'b1;
    @(posedge clk);
    ustart <= 1'b0;
    wait_n(7);
    chk({uact, tact}, 48'h2);
    wait_n(1);
    chk({uact, tact}, 48'h1);
  endtask : overlap

  task automatic read_out(input logic [1:0] sel, input logic [11:0] exp);
    @(posedge clk);
    rdsel <= sel;
    rdstb <= 1'b1;
    @(posedge clk);
    rdstb <= 1'b0;
    @(negedge clk);
    chk({rdval, rdout}, {1'b1, exp});
  endtask : read_out

  task automatic host_pd(input logic [7:0] v);
    @(posedge clk);
    mreq <= 1'b1;
    mval <= v;
    @(posedge clk);
    mreq <= 1'b0;
  endtask : host_pd

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    int n;
    rst_n = 1'b0;
    {above, below, sclr, mode, rdsel, rdstb, ustart, slot, load, otclr, mreq} = '0;
    {raw, off1, off2, codes, mval} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_n(0);
    chk({hiz, alert, refa, refd, flag}, 48'h0);
    chk(tpow, 48'h1);
    chk(taps, 48'hffff_ffff_ffff);
    $display("test reset done");
    @(posedge clk);
    above <= 2'b01;
    wait_n(3);
    chk(flag, 48'h1);
    @(posedge clk);
    sclr <= 2'b01;
    wait_n(2);
    chk(flag, 48'h1);
    @(posedge clk);
    sclr  <= 2'b00;
    above <= 2'b00;
    wait_n(5);
    chk(flag, 48'h1);
    @(posedge clk);
    sclr  <= 2'b01;
    below <= 2'b10;
    wait_n(3);
    chk(flag, 48'h2);
    @(posedge clk);
    below <= 2'b00;
    sclr  <= 2'b10;
    wait_n(5);
    chk(flag, 48'h0);
    @(posedge clk);
    sclr <= 2'b00;
    $display("test shunt done");
    @(posedge clk);
    codes <= {12'h000, 12'hfff, 12'h5a5, 12'h123};
    load  <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    @(negedge clk);
    chk(taps, {12'hfff, 12'h000, 12'ha5a, 12'hedc});
    $display("test dac done");
    @(posedge clk);
    raw  <= 12'h100;
    off1 <= 12'h005;
    off2 <= 12'hffe;
    seek_int();
    conv(2'h0, 12'h105);
    conv(2'h1, 12'h0fe);
    conv(2'h2, 12'h100);
    $display("test temperature done");
    @(posedge clk);
    mode <= 2'h1;
    read_out(2'b10, 12'h0fe);
    read_out(2'b11, 12'h105);
    $display("test readout done");
    overlap(2'h1);
    overlap(2'h2);
    @(posedge clk);
    mode <= 2'h0;
    slot <= 1'b0;
    $display("test handover done");
    raw <= 12'h259;
    host_pd(8'h38);
    wait_n(320);
    chk({hiz, alert, tpow}, 48'h0);
    host_pd(8'h00);
    wait_n(3);
    chk({refa, refd, tpow}, 48'h7);
    n = 0;
    while (settled !== 1'b1 && n < 3100) begin
      @(negedge clk);
      n++;
    end
    chk(settled, 48'h1);
    seek_int();
    wait_n(1);
    chk({hiz, alert}, 48'h3);
    @(posedge clk);
    otclr <= 1'b1;
    wait_n(2);
    chk(alert, 48'h1);
    host_pd(8'h08);
    wait_n(3);
    chk({hiz, alert}, 48'h0);
    @(posedge clk);
    otclr <= 1'b0;
    $display("test shutdown done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
